// >>> verif/wib_ide_model.sv
// Purpose: behavioural ide device with sixteen word registers
// Assumes: register picked by low address nibble
// Notes:   also resolves the shared address/data lines
`timescale 1ns/1ps
module wib_ide_model (
   input  wire logic               clk_i,
   input  wire logic               ior_n_i,
   input  wire logic               iow_n_i,
   input  wire logic               ale_i,
   input  wire wib_pkg::wib_pins_t pins_i,
   output logic [15:0]             bus_o
);
   logic [15:0] mem [16];
   logic [3:0]  sel_r;
   logic [15:0] last_r = 16'h0000;
   logic [15:0] dev;
   always @(posedge clk_i) if (ale_i) sel_r <= pins_i.low_out[3:0];
   always @(posedge clk_i) if (!iow_n_i) mem[sel_r] <= {pins_i.high_out, pins_i.low_out};
   always @(posedge clk_i) if (!ior_n_i) last_r <= mem[sel_r];
   // no pull-ups: a released line shows the inverse of the last word read
   assign dev = !ior_n_i ? mem[sel_r] : ~last_r;
   assign bus_o = {pins_i.high_oe ? pins_i.high_out : dev[15:8],
                   pins_i.low_oe ? pins_i.low_out : dev[7:0]};
endmodule

// >>> verif/wib_port_monitor.sv
// Purpose: timing checks on the wide bus port pins
// Assumes: request fields and mode bits held while busy
// Notes:   bound to every wib_port
`timescale 1ns/1ps
module wib_port_monitor #(
   parameter int STROBE_SHORT = 3,
   parameter int STROBE_LONG  = 15
) (
   input wire logic               clk_i,
   input wire logic               resetn_i,
   input wire logic               wide_bus_enable_i,
   input wire logic               strobe_stretch_bit_i,
   input wire logic               page_access_select_i,
   input wire logic [7:0]         high_port_latch_i,
   input wire wib_pkg::wib_req_t  req_i,
   input wire logic               busy_o,
   input wire logic               done_o,
   input wire logic [7:0]         upper_data_byte_o,
   input wire wib_pkg::wib_pins_t pins_o,
   input wire logic               ale_o,
   input wire logic               p3_7_rd_n_o,
   input wire logic               p3_6_wr_n_o
);
   import wib_pkg::*;
   logic [4:0] cyc_r;
   logic [4:0] low_r;
   logic       str_r;
   always_ff @(posedge clk_i) begin
      cyc_r <= (resetn_i && busy_o) ? cyc_r + 5'h01 : 5'h00;
      low_r <= (resetn_i && !(p3_7_rd_n_o && p3_6_wr_n_o)) ? low_r + 5'h01 : 5'h00;
      if (ale_o) str_r <= strobe_stretch_bit_i;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   AST_IDLE_HIGH: assert property (!busy_o |-> p3_7_rd_n_o && p3_6_wr_n_o)
      else $error("strobe active while idle");
   AST_ALE_PULSE: assert property ($rose(busy_o) |-> ale_o ##1 !ale_o)
      else $error("ale not a single first cycle pulse");
   AST_CYCLE_LEN: assert property (done_o |-> cyc_r == (str_r ? STROBE_LONG : STROBE_SHORT) + 2)
      else $error("bus cycle length wrong");
   AST_STROBE_LEN: assert property ($rose(p3_7_rd_n_o) || $rose(p3_6_wr_n_o)
      |-> low_r == (str_r ? STROBE_LONG : STROBE_SHORT)) else $error("strobe width wrong");
   AST_WR_ROLE: assert property (!p3_6_wr_n_o |-> req_i.write && p3_7_rd_n_o)
      else $error("write strobe on a read");
   AST_WR_DATA: assert property (!p3_6_wr_n_o |-> pins_o.low_oe && pins_o.low_out == req_i.low_data
      && (!wide_bus_enable_i || pins_o.high_oe && pins_o.high_out == upper_data_byte_o))
      else $error("write data wrong");
   AST_RD_FLOAT: assert property (!p3_7_rd_n_o |-> !pins_o.low_oe && !(wide_bus_enable_i && pins_o.high_oe))
      else $error("lines driven during read");
   AST_ADDR_OUT: assert property (ale_o |-> pins_o.low_oe && pins_o.low_out == req_i.addr[7:0]
      && pins_o.high_out == ((req_i.indirect || page_access_select_i) ? high_port_latch_i : req_i.addr[15:8]))
      else $error("address phase value wrong");
   cover property (!p3_6_wr_n_o && wide_bus_enable_i);
   cover property (done_o && str_r);
   cover property (ale_o && req_i.indirect);
endmodule
bind wib_port wib_port_monitor #(.STROBE_SHORT(STROBE_SHORT), .STROBE_LONG(STROBE_LONG))
   wib_port_monitor_inst (.clk_i, .resetn_i, .wide_bus_enable_i, .strobe_stretch_bit_i,
   .page_access_select_i, .high_port_latch_i, .req_i, .busy_o, .done_o, .upper_data_byte_o,
   .pins_o, .ale_o, .p3_7_rd_n_o, .p3_6_wr_n_o);

// >>> verif/wide_ide_bus_port_tb.sv
// Purpose: random word writes and readbacks through the wide bus port
// Assumes: mode bits change only between accesses
// Notes:   inputs driven on the falling edge
`timescale 1ns/1ps
module wide_ide_bus_port_tb;
   import wib_pkg::*;
   logic        clk_i = 0, resetn_i = 0, start_i = 0, sfr_wr_i = 0, page_access_select_i = 0;
   logic        wide_bus_enable_i = 0, strobe_stretch_bit_i = 0;
   logic [7:0]  high_port_latch_i = 8'h00, sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
   logic [7:0]  accumulator_reg_o, upper_data_byte_o;
   logic        busy_o, done_o, ale_o, p3_7_rd_n_o, p3_6_wr_n_o;
   logic [15:0] lines, w;
   wib_req_t    req_i = '0;
   wib_pins_t   pins_o;
   int          failures = 0, num_checks = 0, cycles = 0;
   initial forever #20 clk_i = ~clk_i;
   wib_port wib_port_inst (.clk_i, .resetn_i, .wide_bus_enable_i, .strobe_stretch_bit_i,
      .page_access_select_i, .high_port_latch_i, .start_i, .req_i, .busy_o, .done_o,
      .accumulator_reg_o, .sfr_wr_i, .sfr_addr_i, .sfr_wdata_i, .upper_data_byte_o,
      .low_addr_data_lines_i(lines[7:0]), .high_addr_lines_i(lines[15:8]), .pins_o, .ale_o,
      .p3_7_rd_n_o, .p3_6_wr_n_o);
   // read strobe to io-read, write strobe to io-write
   wib_ide_model wib_ide_model_inst (.clk_i, .ior_n_i(p3_7_rd_n_o), .iow_n_i(p3_6_wr_n_o),
      .ale_i(ale_o), .pins_i(pins_o), .bus_o(lines));
   function automatic logic [7:0] exp_len(input logic s);
      return s ? 8'(WIB_STROBE_LONG + 2) : 8'(WIB_STROBE_SHORT + 2);
   endfunction
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      sfr_wr_i = 1;
      sfr_addr_i = a;
      sfr_wdata_i = d;
      @(negedge clk_i);
      sfr_wr_i = 0;
      @(negedge clk_i);
   endtask
   task automatic access(input logic wr, input logic [3:0] sel, input logic [7:0] d);
      int n;
      req_i = '{write: wr, indirect: 1'($urandom), addr: {12'($urandom), sel}, low_data: d};
      page_access_select_i = 1'($urandom);
      high_port_latch_i = 8'($urandom);
      start_i = 1;
      @(negedge clk_i);
      start_i = 0;
      n = 0;
      while (done_o !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
      check("cycles", exp_len(strobe_stretch_bit_i), 8'(n));
      @(negedge clk_i);
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(32'h87d7));
      repeat (16) @(negedge clk_i);
      resetn_i = 1;
      check("strobes", 8'h03, {6'h00, p3_7_rd_n_o, p3_6_wr_n_o});
      for (int i = 0; i < 30; i++) begin
         w = 16'($urandom);
         wide_bus_enable_i = 1;
         strobe_stretch_bit_i = i[0];
         sfr_write(8'hf9, w[15:8]);
         sfr_write(8'hfa, ~w[15:8]);
         check("upper", w[15:8], upper_data_byte_o);
         access(1'b1, 4'(i), w[7:0]);
         sfr_write(8'hf9, ~w[15:8]);
         wide_bus_enable_i = (i < 2) | 1'($urandom);
         strobe_stretch_bit_i = 1'($urandom);
         access(1'b0, 4'(i), 8'h00);
         check("accumulator", w[7:0], accumulator_reg_o);
         if (wide_bus_enable_i) check("upper", w[15:8], upper_data_byte_o);
      end
      print_verdict();
   end
endmodule

// >>> verilog/wib_pkg.sv
// Purpose: constants and types for the wide external bus port
// Assumes: core clock 25 MHz, one cpu clock period per rising clk_i edge
// Notes:   register offset is a special function register address
package wib_pkg;
   localparam logic [7:0] WIB_UPPER_DATA_OFS = 8'hf9;
   localparam int         WIB_CYCLE_PERIODS   = 6;
   localparam int         WIB_STROBE_SHORT    = 3;
   localparam int         WIB_STROBE_LONG     = 15;
   localparam int         WIB_ADDR_PERIODS    = 2;
   localparam logic [7:0] WIB_UPPER_RESET     = 8'h00;

   typedef enum logic [3:0] {
      WIB_IDLE   = 4'b0001,
      WIB_ADDR   = 4'b0010,
      WIB_STROBE = 4'b0100,
      WIB_HOLD   = 4'b1000
   } wib_state_t;

   // access request from the core
   typedef struct packed {
      logic        write;
      logic        indirect;
      logic [15:0] addr;
      logic [7:0]  low_data;
   } wib_req_t;

   // ports as seen from the pin side
   typedef struct packed {
      logic [7:0] low_out;
      logic       low_oe;
      logic [7:0] high_out;
      logic       high_oe;
   } wib_pins_t;
endpackage

// >>> verilog/wib_port.sv
// Purpose: external move bus cycle engine with optional 16-bit data path
// Assumes: core holds request fields stable while busy_o is high
// Notes:   one external move per start pulse; address phase uses ale_o
//
// Notes on behaviour
// - write and read strobes can be lengthened by the stretch bit.
// - register-indirect move drives high port latch on high lines.
// - pointer move with page access select drives port latch, not pointer high.
// - low port carries data 7..0, high port carries data 15..8.
// - other device controls come from an address latch or port pins.
// - ale marks a valid low address on the low lines.
// - both line groups multiplex address and data.
// - read strobe is port three bit seven, write is bit six.
// - software loads upper byte before write; it is driven during write.
// - every wide read captures high data into the upper byte register.
// - wide bus enable makes each external move a 16-bit transfer.
// - a plain bus cycle spans six cpu clock periods.
// - stretch bit lengthens strobe width from three to fifteen periods.
// - low data byte comes from and returns to the accumulator.
`timescale 1ns/1ps
module wib_port #(
   parameter int STROBE_SHORT = wib_pkg::WIB_STROBE_SHORT,
   parameter int STROBE_LONG  = wib_pkg::WIB_STROBE_LONG
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   // auxiliary control bits
   input  wire logic              wide_bus_enable_i,
   input  wire logic              strobe_stretch_bit_i,
   input  wire logic              page_access_select_i,
   input  wire logic [7:0]        high_port_latch_i,
   // core access request
   input  wire logic              start_i,
   input  wire wib_pkg::wib_req_t req_i,
   output logic                   busy_o,
   output logic                   done_o,
   output logic [7:0]             accumulator_reg_o,
   // special function register access
   input  wire logic              sfr_wr_i,
   input  wire logic [7:0]        sfr_addr_i,
   input  wire logic [7:0]        sfr_wdata_i,
   output logic [7:0]             upper_data_byte_o,
   // pins
   input  wire logic [7:0]        low_addr_data_lines_i,
   input  wire logic [7:0]        high_addr_lines_i,
   output wib_pkg::wib_pins_t     pins_o,
   output logic                   ale_o,
   output logic                   p3_7_rd_n_o,
   output logic                   p3_6_wr_n_o
);
   import wib_pkg::*;

   // port latch stands in for the address high byte
   function automatic logic [7:0] pick_high_addr(
      input logic       indirect,
      input logic       page_sel,
      input logic [7:0] latch,
      input logic [7:0] addr_high
   );
      return (indirect || page_sel) ? latch : addr_high;
   endfunction

   // state and request
   wib_state_t  state_r;
   wib_state_t  state_nxt;
   logic [4:0]  cnt_r;
   logic [4:0]  cnt_nxt;
   wib_req_t    req_r;
   wib_req_t    req_nxt;
   logic        wide_r;
   logic        wide_nxt;
   // data registers
   logic [7:0]  upper_data_byte_r;
   logic [7:0]  upper_data_byte_nxt;
   logic [7:0]  acc_r;
   logic [7:0]  acc_nxt;
   // pin registers
   logic [7:0]  low_out_r;
   logic [7:0]  low_out_nxt;
   logic [7:0]  high_out_r;
   logic [7:0]  high_out_nxt;
   logic        low_oe_r;
   logic        low_oe_nxt;
   logic        high_oe_r;
   logic        high_oe_nxt;
   logic        ale_r;
   logic        ale_nxt;
   logic        rd_n_r;
   logic        rd_n_nxt;
   logic        wr_n_r;
   logic        wr_n_nxt;

   // strobe width chosen at the end of the address phase
   wire  [4:0]  strobe_len    = strobe_stretch_bit_i ? 5'(STROBE_LONG) : 5'(STROBE_SHORT);
   // hold period fills the plain cycle out to six periods
   localparam logic [4:0] HOLD_LEN =
      5'(WIB_CYCLE_PERIODS - WIB_ADDR_PERIODS - WIB_STROBE_SHORT);
   wire         last          = (cnt_r == 5'h01);
   wire         sfr_hit       = sfr_wr_i && (sfr_addr_i == WIB_UPPER_DATA_OFS);
   wire         from_idle     = (state_r == WIB_IDLE);
   wire         take_req      = from_idle && start_i;
   wire         strobe_end    = (state_r == WIB_STROBE) && last;
   wire         read_end      = strobe_end && !req_r.write;
   wire         enter_addr    = (state_nxt == WIB_ADDR);
   wire         enter_strobe  = (state_nxt == WIB_STROBE);
   wire         going_idle    = (state_nxt == WIB_IDLE);
   wire         data_write    = !enter_addr && !going_idle && req_r.write;
   wire         data_read     = !enter_addr && !going_idle && !req_r.write;
   // latch value read live, so software may retarget it mid-cycle
   wire  [7:0]  high_addr     = pick_high_addr(req_r.indirect, page_access_select_i,
                                               high_port_latch_i, req_r.addr[15:8]);
   wire  [7:0]  high_addr_new = pick_high_addr(req_i.indirect, page_access_select_i,
                                               high_port_latch_i, req_i.addr[15:8]);
   // low address shown first so a board latch can hold controls
   wire  [7:0]  addr_low_sel  = from_idle ? req_i.addr[7:0] : req_r.addr[7:0];
   wire  [7:0]  addr_high_sel = from_idle ? high_addr_new : high_addr;
   // upper byte on the high lines of a wide write
   wire  [7:0]  write_high    = wide_r ? upper_data_byte_r : high_addr;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      if (cnt_r != 5'h00) begin
         cnt_nxt = cnt_r - 5'h01;
      end
      case (state_r)
         WIB_IDLE: begin
            if (start_i) begin
               state_nxt = WIB_ADDR;
               cnt_nxt   = 5'(WIB_ADDR_PERIODS);
            end
         end
         WIB_ADDR: begin
            if (last) begin
               state_nxt = WIB_STROBE;
               cnt_nxt   = strobe_len;
            end
         end
         WIB_STROBE: begin
            if (last) begin
               state_nxt = WIB_HOLD;
               cnt_nxt   = HOLD_LEN;
            end
         end
         WIB_HOLD: begin
            if (last) begin
               state_nxt = WIB_IDLE;
            end
         end
         default: begin
            state_nxt = WIB_IDLE;
            cnt_nxt   = 5'h00;
         end
      endcase
   end

   // width and request fixed for the whole transfer
   assign req_nxt  = take_req ? req_i : req_r;
   assign wide_nxt = take_req ? wide_bus_enable_i : wide_r;
   // low byte into the accumulator at the end of a read
   assign acc_nxt  = read_end ? low_addr_data_lines_i : acc_r;
   // capture high byte on wide read; it beats a software write
   // software preload of the upper byte
   assign upper_data_byte_nxt = (read_end && wide_r)   ? high_addr_lines_i :
                                (!read_end && sfr_hit) ? sfr_wdata_i : upper_data_byte_r;

   // ale for the first address period only
   assign ale_nxt  = enter_addr && (cnt_nxt == 5'(WIB_ADDR_PERIODS));
   assign rd_n_nxt = !(enter_strobe && !req_r.write);
   assign wr_n_nxt = !(enter_strobe && req_r.write);
   // address, then accumulator byte on a write
   assign low_out_nxt  = enter_addr ? addr_low_sel :
                         data_write ? req_r.low_data : low_out_r;
   assign low_oe_nxt   = enter_addr || data_write;
   // address, then upper byte or address high byte
   assign high_out_nxt = enter_addr ? addr_high_sel :
                         data_write ? write_high :
                         data_read  ? high_addr : high_out_r;
   // narrow read keeps the address high byte driven on the high lines
   assign high_oe_nxt  = enter_addr || data_write || (data_read && !wide_r);

   // one short register per signal; reset values are constants only
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_r <= WIB_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cnt_r <= 5'h00;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         req_r <= '0;
      end else begin
         req_r <= req_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wide_r <= 1'b0;
      end else begin
         wide_r <= wide_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         acc_r <= 8'h00;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   // known reset value; software loads it before any wide write
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         upper_data_byte_r <= WIB_UPPER_RESET;
      end else begin
         upper_data_byte_r <= upper_data_byte_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         low_out_r <= 8'h00;
      end else begin
         low_out_r <= low_out_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         high_out_r <= 8'h00;
      end else begin
         high_out_r <= high_out_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         low_oe_r <= 1'b0;
      end else begin
         low_oe_r <= low_oe_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         high_oe_r <= 1'b0;
      end else begin
         high_oe_r <= high_oe_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ale_r <= 1'b0;
      end else begin
         ale_r <= ale_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         rd_n_r <= 1'b1;
      end else begin
         rd_n_r <= rd_n_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_n_r <= 1'b1;
      end else begin
         wr_n_r <= wr_n_nxt;
      end
   end

   assign busy_o            = (state_r != WIB_IDLE);
   assign done_o            = (state_r == WIB_HOLD) && last;
   assign accumulator_reg_o = acc_r;
   assign upper_data_byte_o = upper_data_byte_r;
   assign pins_o.low_out    = low_out_r;
   assign pins_o.low_oe     = low_oe_r;
   assign pins_o.high_out   = high_out_r;
   assign pins_o.high_oe    = high_oe_r;
   assign ale_o             = ale_r;
   assign p3_7_rd_n_o       = rd_n_r;
   assign p3_6_wr_n_o       = wr_n_r;
endmodule
